//--- pin_share_pkg.sv
// constants, pin indices, carriers and state types for the shared test port pins
// assumes a consumer that writes every use as pin_share_pkg::name
package pin_share_pkg;

  // ==========================================================================
  // pin indices within the seven-line pin vectors
  localparam int NUM_LINES = 7;
  localparam int LINE_ZERO = 0;
  localparam int LINE_ONE = 1;
  localparam int LINE_TWO = 2;
  localparam int LINE_THREE = 3;
  localparam int LINE_FIVE = 4;
  localparam int LINE_SIX = 5;
  localparam int LINE_SEVEN = 6;

  // ==========================================================================
  // pin configuration and its reset defaults
  typedef struct packed {
    logic [NUM_LINES-1:0] alt;
    logic [NUM_LINES-1:0] dir;
    logic [NUM_LINES-1:0] out;
    logic [NUM_LINES-1:0] pull;
  } gpio_cfg_t;

  // test lines start in test function, the rest as plain inputs
  localparam logic [NUM_LINES-1:0] ALT_RESET = 7'h0F;
  localparam logic [NUM_LINES-1:0] DIR_RESET = 7'h00;
  localparam logic [NUM_LINES-1:0] OUT_RESET = 7'h00;
  localparam logic [NUM_LINES-1:0] PULL_RESET = 7'h6F;
  localparam gpio_cfg_t CFG_RESET = '{alt: ALT_RESET, dir: DIR_RESET, out: OUT_RESET, pull: PULL_RESET};

  // ==========================================================================
  // test access port
  localparam int WORD_W = 16;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_DATA_WORD = 4'h4;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

  // ==========================================================================
  // per-domain state
  typedef struct packed {
    tap_state_t state;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir;
    logic [WORD_W-1:0] dr;
    logic bypass;
    logic [WORD_W-1:0] word;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic alt_s1;
    logic alt_s2;
  } tck_state_t;

  typedef struct packed {
    logic out;
    logic oe;
  } tdo_state_t;

  typedef struct packed {
    gpio_cfg_t cfg;
    logic [NUM_LINES-1:0] sync1;
    logic [NUM_LINES-1:0] sync2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic ref_sel;
  } mclk_state_t;

  typedef struct packed {
    logic head_valid;
    logic [WORD_W-1:0] head;
    logic skid_valid;
    logic [WORD_W-1:0] skid;
  } buf_state_t;

endpackage

//--- word_buffer.sv
// two-entry buffer between the crossed test word and the word consumer
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module word_buffer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [pin_share_pkg::WORD_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [pin_share_pkg::WORD_W-1:0] out_data
);
  pin_share_pkg::buf_state_t s;
  pin_share_pkg::buf_state_t next_s;
  logic pop;
  logic push;

  // ==========================================================================
  // head feeds the consumer, skid catches a word while head stalls
  assign pop = s.head_valid && out_ready;
  assign push = in_valid && !s.skid_valid;
  assign in_ready = !s.skid_valid;
  assign out_valid = s.head_valid;
  assign out_data = s.head;

  always_comb
  begin
    next_s = s;
    if (pop)
    begin
      next_s.head = s.skid;
      next_s.head_valid = s.skid_valid;
      next_s.skid_valid = 1'b0;
    end
    if (push)
    begin
      if (!next_s.head_valid)
      begin
        next_s.head = in_data;
        next_s.head_valid = 1'b1;
      end
      else
      begin
        next_s.skid = in_data;
        next_s.skid_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  property p_hold_stalled;
    @(posedge clk) disable iff (!rst_n)
      (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
  endproperty
  a_hold_stalled: assert property (p_hold_stalled) else $error("stalled word changed");

endmodule
`default_nettype wire

//--- test_port_pin_sharing.sv
// shared test port pins: tap controller on the test clock, pin muxing on MCLK
// assumes the test clock arrives on line two and that the host keeps tdi and tms stable around rising edges
`timescale 1ns/1ns
`default_nettype none
module test_port_pin_sharing
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [pin_share_pkg::NUM_LINES-1:0] PIN_IN,
  output logic [pin_share_pkg::NUM_LINES-1:0] PIN_OUT,
  output logic [pin_share_pkg::NUM_LINES-1:0] PIN_OE,
  output logic [pin_share_pkg::NUM_LINES-1:0] PULLUP_EN,
  input wire logic CFG_WR,
  input wire pin_share_pkg::gpio_cfg_t CFG_DATA,
  output logic [pin_share_pkg::NUM_LINES-1:0] GPIO_IN,
  output logic [pin_share_pkg::WORD_W-1:0] RX_WORD,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic REF_CLK_SELECT,
  output logic EXT_REF_CLK,
  output logic [1:0] CONV_OUT_EN
);
  pin_share_pkg::tck_state_t t;
  pin_share_pkg::tck_state_t next_t;
  pin_share_pkg::tdo_state_t d;
  pin_share_pkg::tdo_state_t next_d;
  pin_share_pkg::mclk_state_t m;
  pin_share_pkg::mclk_state_t next_m;
  logic test_clk;
  logic tdi;
  logic tms_eff;
  logic busy;
  logic pending;
  logic buf_in_ready;

  // ==========================================================================
  // test clock domain
  // host-made test clock
  assign test_clk = PIN_IN[pin_share_pkg::LINE_TWO];
  assign tdi = PIN_IN[pin_share_pkg::LINE_ZERO];
  // line three taken for port use holds the controller in reset, as with mode select tied high
  assign tms_eff = t.alt_s2 ? PIN_IN[pin_share_pkg::LINE_THREE] : 1'b1;
  // a word is in flight until the MCLK side has returned the toggle
  assign busy = t.req != t.ack_s2;

  always_comb
  begin
    next_t = t;
    next_t.ack_s1 = m.ack;
    next_t.ack_s2 = t.ack_s1;
    next_t.alt_s1 = m.cfg.alt[pin_share_pkg::LINE_THREE];
    next_t.alt_s2 = t.alt_s1;
    case (t.state)
      pin_share_pkg::ST_RESET:
        next_t.state = tms_eff ? pin_share_pkg::ST_RESET : pin_share_pkg::ST_IDLE;
      pin_share_pkg::ST_IDLE:
        next_t.state = tms_eff ? pin_share_pkg::ST_SEL_DR : pin_share_pkg::ST_IDLE;
      pin_share_pkg::ST_SEL_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_SEL_IR : pin_share_pkg::ST_CAP_DR;
      pin_share_pkg::ST_CAP_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_EXIT1_DR : pin_share_pkg::ST_SHIFT_DR;
      pin_share_pkg::ST_SHIFT_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_EXIT1_DR : pin_share_pkg::ST_SHIFT_DR;
      pin_share_pkg::ST_EXIT1_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_UPD_DR : pin_share_pkg::ST_PAUSE_DR;
      pin_share_pkg::ST_PAUSE_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_EXIT2_DR : pin_share_pkg::ST_PAUSE_DR;
      pin_share_pkg::ST_EXIT2_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_UPD_DR : pin_share_pkg::ST_SHIFT_DR;
      pin_share_pkg::ST_UPD_DR:
        next_t.state = tms_eff ? pin_share_pkg::ST_SEL_DR : pin_share_pkg::ST_IDLE;
      pin_share_pkg::ST_SEL_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_RESET : pin_share_pkg::ST_CAP_IR;
      pin_share_pkg::ST_CAP_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_EXIT1_IR : pin_share_pkg::ST_SHIFT_IR;
      pin_share_pkg::ST_SHIFT_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_EXIT1_IR : pin_share_pkg::ST_SHIFT_IR;
      pin_share_pkg::ST_EXIT1_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_UPD_IR : pin_share_pkg::ST_PAUSE_IR;
      pin_share_pkg::ST_PAUSE_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_EXIT2_IR : pin_share_pkg::ST_PAUSE_IR;
      pin_share_pkg::ST_EXIT2_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_UPD_IR : pin_share_pkg::ST_SHIFT_IR;
      pin_share_pkg::ST_UPD_IR:
        next_t.state = tms_eff ? pin_share_pkg::ST_SEL_DR : pin_share_pkg::ST_IDLE;
      default:
        next_t.state = pin_share_pkg::ST_RESET;
    endcase
    // serial data taken on the rising edge
    case (t.state)
      pin_share_pkg::ST_RESET:
        next_t.ir = pin_share_pkg::IR_BYPASS;
      pin_share_pkg::ST_CAP_IR:
        next_t.ir_shift = pin_share_pkg::IR_CAPTURE;
      pin_share_pkg::ST_SHIFT_IR:
        next_t.ir_shift = {tdi, t.ir_shift[pin_share_pkg::IR_W-1:1]};
      pin_share_pkg::ST_UPD_IR:
        next_t.ir = t.ir_shift;
      pin_share_pkg::ST_CAP_DR:
      begin
        // the first bit out tells the host whether the last word is still pending
        next_t.dr = {{(pin_share_pkg::WORD_W-1){1'b0}}, busy};
        next_t.bypass = 1'b0;
      end
      pin_share_pkg::ST_SHIFT_DR:
      begin
        if (t.ir == pin_share_pkg::IR_DATA_WORD)
          next_t.dr = {tdi, t.dr[pin_share_pkg::WORD_W-1:1]};
        else
          next_t.bypass = tdi;
      end
      pin_share_pkg::ST_UPD_DR:
      begin
        // a word written while busy is dropped; the host sees busy on the next capture
        if (t.ir == pin_share_pkg::IR_DATA_WORD && !busy)
        begin
          next_t.word = t.dr;
          next_t.req = ~t.req;
        end
      end
      default:
      begin
      end
    endcase
  end

  // the controller has no clocked reset release because the test clock may be stopped
  always_ff @(posedge test_clk or negedge RSTN)
  begin
    if (!RSTN)
      t <= '{state: pin_share_pkg::ST_RESET, ir: pin_share_pkg::IR_BYPASS, default: '0};
    else
      t <= next_t;
  end

  // ==========================================================================
  // test data output on the falling edge
  always_comb
  begin
    next_d = d;
    next_d.oe = (t.state == pin_share_pkg::ST_SHIFT_IR) || (t.state == pin_share_pkg::ST_SHIFT_DR);
    if (t.state == pin_share_pkg::ST_SHIFT_IR)
      next_d.out = t.ir_shift[0];
    else if (t.ir == pin_share_pkg::IR_DATA_WORD)
      next_d.out = t.dr[0];
    else
      next_d.out = t.bypass;
  end

  always_ff @(negedge test_clk or negedge RSTN)
  begin
    if (!RSTN)
      d <= '0;
    else
      d <= next_d;
  end

  // ==========================================================================
  // MCLK domain: pin configuration, input synchronisers, word crossing
  assign pending = m.req_s2 != m.ack;

  always_comb
  begin
    next_m = m;
    next_m.sync1 = PIN_IN;
    next_m.sync2 = m.sync1;
    next_m.req_s1 = t.req;
    next_m.req_s2 = m.req_s1;
    if (CFG_WR)
      next_m.cfg = CFG_DATA;
    // the word stays stable in the test domain until this toggle is seen there
    if (pending && buf_in_ready)
      next_m.ack = ~m.ack;
    next_m.ref_sel = m.cfg.alt[pin_share_pkg::LINE_FIVE];
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      m <= '{cfg: pin_share_pkg::CFG_RESET, default: '0};
    else
      m <= next_m;
  end

  word_buffer u_buf
  (
    .clk(MCLK),
    .rst_n(RSTN),
    .in_valid(pending),
    .in_ready(buf_in_ready),
    .in_data(t.word),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_WORD)
  );

  // ==========================================================================
  // pin drivers
  genvar i;
  generate
    for (i = 0; i < pin_share_pkg::NUM_LINES; i++)
    begin : g_line
      if (i == pin_share_pkg::LINE_ONE)
      begin : g_tdo
        assign PIN_OUT[i] = m.cfg.alt[i] ? d.out : m.cfg.out[i];
        assign PIN_OE[i] = m.cfg.alt[i] ? d.oe : m.cfg.dir[i];
      end
      else
      begin : g_plain
        // alternate functions of the other lines are inputs or analog
        assign PIN_OUT[i] = m.cfg.out[i];
        assign PIN_OE[i] = !m.cfg.alt[i] && m.cfg.dir[i];
      end
    end
  endgenerate

  assign PULLUP_EN = m.cfg.pull;
  assign GPIO_IN = m.sync2;
  assign REF_CLK_SELECT = m.ref_sel;
  assign CONV_OUT_EN = {m.cfg.alt[pin_share_pkg::LINE_SEVEN], m.cfg.alt[pin_share_pkg::LINE_SIX]};
  // external reference clock path; a clock cannot pass a flip-flop, so this is a gate
  assign EXT_REF_CLK = m.ref_sel && PIN_IN[pin_share_pkg::LINE_FIVE];

  // ==========================================================================
  // checks
  property p_tdo_drive;
    @(posedge test_clk) disable iff (!RSTN)
      (t.state == pin_share_pkg::ST_SHIFT_DR) |-> d.oe;
  endproperty
  a_tdo_drive: assert property (p_tdo_drive) else $error("tdo not driven in shift-DR");

  property p_tdo_release;
    @(posedge test_clk) disable iff (!RSTN)
      (t.state == pin_share_pkg::ST_IDLE) ##1 (t.state == pin_share_pkg::ST_IDLE) |-> !d.oe;
  endproperty
  a_tdo_release: assert property (p_tdo_release) else $error("tdo driven in idle");

  property p_tdo_fall;
    @(posedge MCLK) disable iff (!RSTN)
      $changed(d.out) |-> !test_clk;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed with test clock high");

  property p_tms_reset;
    @(posedge test_clk) disable iff (!RSTN)
      tms_eff [*5] |=> (t.state == pin_share_pkg::ST_RESET);
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five mode-select highs did not reset");

  property p_tdi_sample;
    @(posedge test_clk) disable iff (!RSTN)
      (t.state == pin_share_pkg::ST_SHIFT_DR && t.ir == pin_share_pkg::IR_DATA_WORD)
        |=> (t.dr[pin_share_pkg::WORD_W-1] == $past(tdi));
  endproperty
  a_tdi_sample: assert property (p_tdi_sample) else $error("tdi bit not shifted in");

  property p_cfg_write;
    @(posedge MCLK) disable iff (!RSTN)
      CFG_WR |=> (m.cfg.dir == $past(CFG_DATA.dir)) && (m.cfg.alt == $past(CFG_DATA.alt));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("pin configuration not taken");

  property p_gpio_drive;
    @(posedge MCLK) disable iff (!RSTN)
      (!m.cfg.alt[pin_share_pkg::LINE_SIX]) |-> (PIN_OE[pin_share_pkg::LINE_SIX] == m.cfg.dir[pin_share_pkg::LINE_SIX]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("port line direction ignored");

  property p_reset_test;
    @(posedge MCLK) disable iff (!RSTN)
      $rose(RSTN) |-> (m.cfg.alt[pin_share_pkg::LINE_THREE:pin_share_pkg::LINE_ZERO] == 4'hF)
        && !PIN_OE[pin_share_pkg::LINE_ONE];
  endproperty
  a_reset_test: assert property (p_reset_test) else $error("test lines not default after reset");

  property p_reset_port;
    @(posedge MCLK) disable iff (!RSTN)
      $rose(RSTN) |-> (m.cfg.alt[pin_share_pkg::LINE_SEVEN:pin_share_pkg::LINE_FIVE] == 3'h0)
        && (PIN_OE[pin_share_pkg::LINE_SEVEN:pin_share_pkg::LINE_FIVE] == 3'h0)
        && (PULLUP_EN[pin_share_pkg::LINE_SEVEN:pin_share_pkg::LINE_SIX] == 2'h3);
  endproperty
  a_reset_port: assert property (p_reset_port) else $error("port lines not default after reset");

  property p_ref_gate;
    @(posedge MCLK) disable iff (!RSTN)
      !m.cfg.alt[pin_share_pkg::LINE_FIVE] ##1 !m.cfg.alt[pin_share_pkg::LINE_FIVE] |-> !EXT_REF_CLK;
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("reference clock leaks while unselected");

endmodule
`default_nettype wire

//--- tap_host.sv
// behavioural boundary-scan host driving the shared test pins
// assumes the bench resolves the tdo wire, with its pull-up, from the pin enables
`timescale 1ns/1ns
`default_nettype none
module tap_host
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // ==========================================
  // idle levels
  // test clock stands still low between frames; data lines rest at pull-up level
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // ==========================================
  // one test clock period
  // present tms tdi, clock
  // lines change after the falling edge and hold through the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #63;
    tck = 1'b1;
    q = tdo;
    #62;
    tck = 1'b0;
  endtask

  // ==========================================
  // frames
  task automatic reset_tap();
    logic q;
    repeat (6) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask

  // from idle through shift back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic q;
    dout = 16'h0000;
    step(1'b1, 1'b1, q);
    if (ir)
    begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tms = 1'b1;
    tdi = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the shared test port pins
// assumes tap_host on the test pins and a random word consumer on the rx side
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic MCLK;
  logic RSTN;
  logic CFG_WR;
  logic RX_READY;
  pin_share_pkg::gpio_cfg_t CFG_DATA;
  logic [6:0] PIN_IN;
  logic [6:0] PIN_OUT;
  logic [6:0] PIN_OE;
  logic [6:0] PULLUP_EN;
  logic [6:0] GPIO_IN;
  logic [15:0] RX_WORD;
  logic RX_VALID;
  logic REF_CLK_SELECT;
  logic EXT_REF_CLK;
  logic [1:0] CONV_OUT_EN;
  logic tck;
  logic tms;
  logic tdi;
  logic [2:0] gp_drv;
  logic [6:0] ext;
  logic rdy_mode;
  logic tap_phase;
  int seed = 32276;
  int n_fail = 0;
  int n_checks = 0;
  logic [15:0] expq[$];
  logic [15:0] gotq[$];

  // ==========================================
  // clock, pins, instances
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // line one rests high through its pull-up when nobody drives it
  assign ext = {gp_drv, tms, tck, 1'b1, tdi};
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & ext);

  tap_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(PIN_IN[1]));

  test_port_pin_sharing dut_u (.MCLK(MCLK), .RSTN(RSTN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN), .CFG_WR(CFG_WR), .CFG_DATA(CFG_DATA), .GPIO_IN(GPIO_IN),
    .RX_WORD(RX_WORD), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .REF_CLK_SELECT(REF_CLK_SELECT),
    .EXT_REF_CLK(EXT_REF_CLK), .CONV_OUT_EN(CONV_OUT_EN));

  // ==========================================
  // consumer and monitors
  // a pop is known half a cycle ahead, so the word is taken while it stands
  always @(negedge MCLK)
  begin
    logic r;
    r = rdy_mode & 1'($random(seed));
    if (RSTN && RX_VALID && r)
    begin
      gotq.push_back(RX_WORD);
    end
    RX_READY <= r;
  end

  // tdo may only move while the test clock is low
  always @(PIN_OUT[1] or PIN_OE[1])
  begin
    if (tap_phase && tck)
    begin
      chk(16'h0001, 16'h0000);
    end
  end

  // ==========================================
  // checking and closing
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic give_verdict();
    $display("n_checks=%0d n_fail=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [6:0] lvl_exp(pin_share_pkg::gpio_cfg_t c, logic [6:0] e);
    return ((~c.alt & c.dir) & c.out) | (~(~c.alt & c.dir) & e);
  endfunction

  task automatic chk_defaults();
    chk(16'(PIN_OE), 16'h0000);
    chk(16'(PULLUP_EN), 16'h006F);
    chk(16'(CONV_OUT_EN), 16'h0000);
    chk(16'(REF_CLK_SELECT), 16'h0000);
    chk(16'(RX_VALID), 16'h0000);
  endtask

  task automatic write_cfg(input pin_share_pkg::gpio_cfg_t c);
    logic [6:0] oe;
    logic [6:0] msk;
    oe = ~c.alt & c.dir;
    msk = c.alt[1] ? 7'h7D : 7'h7F;
    CFG_DATA = c;
    CFG_WR = 1'b1;
    @(negedge MCLK);
    CFG_WR = 1'b0;
    @(negedge MCLK);
    chk(16'(PIN_OE), 16'(oe));
    chk(16'(PIN_OUT & msk), 16'(c.out & msk));
    chk(16'(PULLUP_EN), 16'(c.pull));
    chk(16'(CONV_OUT_EN), 16'({c.alt[6], c.alt[5]}));
    @(negedge MCLK);
    chk(16'(REF_CLK_SELECT), 16'(c.alt[4]));
    chk(16'(EXT_REF_CLK), 16'(c.alt[4] & gp_drv[0]));
    repeat (4) @(negedge MCLK);
    chk(16'(GPIO_IN), 16'(lvl_exp(c, ext)));
  endtask

  task automatic drain();
    rdy_mode = 1'b1;
    for (int k = 0; k < 2000 && gotq.size() < expq.size(); k++)
      @(negedge MCLK);
    repeat (100) @(negedge MCLK);
    chk(16'(gotq.size()), 16'(expq.size()));
    foreach (expq[k])
      if (k < gotq.size())
        chk(gotq[k], expq[k]);
    expq.delete();
    gotq.delete();
  endtask

  initial
  begin
    #300000;
    n_fail++;
    give_verdict();
  end

  // ==========================================
  // main sequence
  initial
  begin
    pin_share_pkg::gpio_cfg_t c;
    logic [15:0] w;
    logic [15:0] d;
    RSTN = 1'b0;
    CFG_WR = 1'b0;
    CFG_DATA = pin_share_pkg::CFG_RESET;
    gp_drv = 3'h0;
    rdy_mode = 1'b0;
    tap_phase = 1'b0;
    repeat (4) @(negedge MCLK);
    chk_defaults();
    RSTN = 1'b1;
    @(negedge MCLK);
    chk_defaults();
    // random pin configurations; test input lines kept as inputs to avoid a fight with the host
    for (int i = 0; i < 16; i++)
    begin
      c = 28'($random(seed));
      c.dir[0] = 1'b0;
      c.dir[2] = 1'b0;
      c.dir[3] = 1'b0;
      gp_drv = 3'($random(seed));
      write_cfg(c);
    end
    // reset in mid-run must restore every default
    RSTN = 1'b0;
    @(negedge MCLK);
    chk_defaults();
    RSTN = 1'b1;
    @(negedge MCLK);
    tap_phase = 1'b1;
    host_u.reset_tap();
    host_u.scan(1'b1, 4, 16'h0004, d);
    chk(d, 16'h0001);
    chk(16'(PIN_OE[1]), 16'h0000);
    host_u.scan(1'b1, 4, 16'h000F, d);
    w = 16'($random(seed));
    host_u.scan(1'b0, 8, w, d);
    chk(d, {8'h00, w[6:0], 1'b0});
    host_u.scan(1'b1, 4, 16'h0004, d);
    // stream of words with the consumer stalling at random
    rdy_mode = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      w = 16'($random(seed));
      host_u.scan(1'b0, 16, w, d);
      expq.push_back(w);
    end
    drain();
    // fill both entries plus one held in the crossing, then a word that must be refused
    rdy_mode = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      w = (i == 0) ? 16'hFFFF : 16'($random(seed));
      host_u.scan(1'b0, 16, w, d);
      expq.push_back(w);
    end
    host_u.scan(1'b0, 16, 16'hA5A5, d);
    chk(d, 16'h0001);
    drain();
    give_verdict();
  end
endmodule
`default_nettype wire
